// *** hw/adc_seq_pkg.sv ***
// shared constants for the serial converter readout sequencer
package adc_seq_pkg;

  // ------------------------------------------------------------------
  // result word and shift framing
  // ------------------------------------------------------------------
  localparam int RESULT_W      = 8;
  localparam int SHIFT_CNT_W   = 4;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] RESULT_ONES  = 8'hFF;
  localparam logic [7:0] RESULT_ZERO  = 8'h00;
  localparam logic [7:0] SAR_FIRST_MASK = 8'h80;
  // falling edge count that starts a conversion
  localparam logic [3:0] START_EDGE   = 4'h8;

  // ------------------------------------------------------------------
  // conversion timing on the system clock
  // ------------------------------------------------------------------
  localparam int SYS_PERIOD_NS  = 20;
  localparam int CONV_CYCLES    = 36;
  localparam int CONV_MAX_NS    = 17000;
  // longest time rounds down to whole cycles
  localparam int CONV_MAX_CYC   = CONV_MAX_NS / SYS_PERIOD_NS;
  localparam int SETTLE_CYCLES  = 4;
  localparam int BIT_CYCLES     = 4;
  localparam int CONV_CNT_W     = 6;
  localparam int PHASE_W        = 2;

  // ------------------------------------------------------------------
  // select filtering and buffering
  // ------------------------------------------------------------------
  localparam int DEB_CYCLES     = 2;
  localparam int DEB_CNT_W      = 2;
  localparam int FIFO_DEPTH     = 16;
  localparam int SAMPLE_W       = 10;

endpackage

// *** hw/sample_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  // honest flags straight from the occupancy count
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ff];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (push && !pop) begin
      cnt_ff <= cnt_ff + 1'b1;
    end else if (pop && !push) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule

// *** hw/serial_shifter.sv ***
// shift-clock side: edge counter, bit select and conversion request toggle
`timescale 1ns/100ps
module serial_shifter (
  input  wire logic       io_clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic [7:0] word,
  output logic            bit_out,
  output logic            start_tgl
);

  logic [adc_seq_pkg::SHIFT_CNT_W-1:0] edge_cnt_ff;
  logic                                tgl_ff;
  logic [2:0]                          bit_sel;

  // ------------------------------------------------------------------
  // falling edge counter
  // ------------------------------------------------------------------
  // clr is a flop from the system domain; the shift clock is still
  // while it releases, so the release cannot race an edge
  always_ff @(negedge io_clk or posedge clr) begin
    if (clr) begin
      edge_cnt_ff <= '0;
    end else if (edge_cnt_ff != adc_seq_pkg::START_EDGE) begin
      edge_cnt_ff <= edge_cnt_ff + 1'b1;
    end
  end

  // one bit per falling edge
  // msb at count zero, lsb held once seven edges are done
  assign bit_sel = edge_cnt_ff[3] ? 3'h0 : 3'h7 - edge_cnt_ff[2:0];
  assign bit_out = word[bit_sel];

  // ------------------------------------------------------------------
  // conversion request
  // ------------------------------------------------------------------
  // eighth falling edge toggles
  // a toggle survives a select that rises right after the edge
  always_ff @(negedge io_clk or posedge rst) begin
    if (rst) begin
      tgl_ff <= 1'b0;
    end else if (edge_cnt_ff == adc_seq_pkg::START_EDGE - 4'h1) begin
      tgl_ff <= ~tgl_ff;
    end
  end

  assign start_tgl = tgl_ff;

endmodule

// *** hw/serial_adc_readout_sequencer.sv ***
// readout and conversion sequencer of an 8-bit serial converter
`timescale 1ns/100ps
module serial_adc_readout_sequencer #(
  parameter int SAMPLE_W   = adc_seq_pkg::SAMPLE_W,
  parameter int FIFO_DEPTH = adc_seq_pkg::FIFO_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                io_clk,
  input  wire logic                sel_n,
  output logic                     sdo,
  output logic                     sdo_oe,
  input  wire logic                ain_valid,
  input  wire logic [SAMPLE_W-1:0] ain_data,
  output logic                     ain_ready,
  input  wire logic [SAMPLE_W-1:0] ref_hi,
  input  wire logic [SAMPLE_W-1:0] ref_lo,
  output logic                     busy,
  output logic [7:0]               result,
  output logic                     hold_violation
);

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_CONV
  } conv_state_t;

  // ------------------------------------------------------------------
  // threshold for a trial code between the two references
  // ------------------------------------------------------------------
  function automatic logic [SAMPLE_W-1:0] trial_level(
    input logic [7:0]          code,
    input logic [SAMPLE_W-1:0] lo,
    input logic [SAMPLE_W-1:0] hi
  );
    logic [SAMPLE_W-1:0] span;
    logic [SAMPLE_W+7:0] prod;
    span = hi - lo;
    prod = span * code;
    return lo + prod[SAMPLE_W+7:8];
  endfunction

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic                                sel_meta_ff;
  logic                                sel_sync_ff;
  logic [adc_seq_pkg::DEB_CNT_W-1:0]   deb_cnt_ff;
  logic                                access_ff;
  logic                                access_go;
  logic [7:0]                          snap_ff;
  logic [7:0]                          out_ff;
  conv_state_t                         state_ff;
  logic [adc_seq_pkg::CONV_CNT_W-1:0]  cyc_ff;
  logic [adc_seq_pkg::PHASE_W-1:0]     phase_ff;
  logic [7:0]                          sar_ff;
  logic [7:0]                          mask_ff;
  logic [SAMPLE_W-1:0]                 sample_ff;
  logic                                hold_viol_ff;
  logic                                tgl_meta_ff;
  logic                                tgl_sync_ff;
  logic                                tgl_seen_ff;
  logic                                start_evt;
  logic                                conv_go;
  logic                                conv_last;
  logic                                decide;
  logic                                trial_ok;
  logic [7:0]                          trial_code;
  logic [7:0]                          nxt_result;
  logic                                fifo_valid;
  logic [SAMPLE_W-1:0]                 fifo_data;
  logic                                fifo_pop;
  logic                                link_start_tgl;
  logic                                link_bit;
  logic                                link_clr;

  // ------------------------------------------------------------------
  // select pin synchroniser
  // ------------------------------------------------------------------
  // two stages, idle high so a reset never looks like an access
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_meta_ff <= 1'b1;
      sel_sync_ff <= 1'b1;
    end else begin
      sel_meta_ff <= sel_n;
      sel_sync_ff <= sel_meta_ff;
    end
  end

  // ------------------------------------------------------------------
  // select filter
  // ------------------------------------------------------------------
  // low must persist before acceptance
  // short low glitches restart the count and never open an access
  always_ff @(posedge clk) begin
    if (rst) begin
      deb_cnt_ff <= '0;
    end else if (sel_sync_ff) begin
      deb_cnt_ff <= '0;
    end else if (deb_cnt_ff != adc_seq_pkg::DEB_CNT_W'(adc_seq_pkg::DEB_CYCLES)) begin
      deb_cnt_ff <= deb_cnt_ff + 1'b1;
    end
  end

  assign access_go = !access_ff && !sel_sync_ff &&
                     (deb_cnt_ff == adc_seq_pkg::DEB_CNT_W'(adc_seq_pkg::DEB_CYCLES));

  // access window, closed as soon as the synced select is high
  always_ff @(posedge clk) begin
    if (rst) begin
      access_ff <= 1'b0;
    end else if (sel_sync_ff) begin
      access_ff <= 1'b0;
    end else if (access_go) begin
      access_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // readout word
  // ------------------------------------------------------------------
  // held result enters the shift path
  // previous conversion read this access
  // the copy stays frozen for the whole access, so a conversion that
  // ends meanwhile cannot tear the word being shifted
  always_ff @(posedge clk) begin
    if (rst) begin
      snap_ff <= adc_seq_pkg::RESULT_RESET;
    end else if (access_go) begin
      snap_ff <= out_ff;
    end
  end

  // early select low is flagged
  // the readout then repeats the older result
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_viol_ff <= 1'b0;
    end else if (access_go) begin
      hold_viol_ff <= (state_ff == ST_CONV);
    end
  end

  // ------------------------------------------------------------------
  // shift-clock side
  // ------------------------------------------------------------------
  // lead time lets the word settle
  // the shifter reads snap_ff quasi-statically; it is written only at
  // access_go, well before the host may give a first edge
  assign link_clr = !access_ff;

  serial_shifter u_shifter (
    .io_clk    (io_clk),
    .rst       (rst),
    .clr       (link_clr),
    .word      (snap_ff),
    .bit_out   (link_bit),
    .start_tgl (link_start_tgl)
  );

  assign sdo_oe = access_ff;
  assign sdo    = access_ff ? link_bit : 1'b0;

  // ------------------------------------------------------------------
  // start request crossing
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_meta_ff <= 1'b0;
      tgl_sync_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else begin
      tgl_meta_ff <= link_start_tgl;
      tgl_sync_ff <= tgl_meta_ff;
      tgl_seen_ff <= tgl_sync_ff;
    end
  end

  assign start_evt = tgl_sync_ff ^ tgl_seen_ff;
  assign conv_go   = start_evt && (state_ff == ST_IDLE);

  // ------------------------------------------------------------------
  // sample buffer
  // ------------------------------------------------------------------
  // one word leaves per conversion; a source faster than the access
  // rate is stalled by ain_ready once the buffer is full
  assign fifo_pop = conv_go;

  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (ain_valid),
    .in_data   (ain_data),
    .in_ready  (ain_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  // sample taken at conversion start
  // an empty buffer keeps the last sample rather than stalling
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_ff <= '0;
    end else if (conv_go && fifo_valid) begin
      sample_ff <= fifo_data;
    end
  end

  // ------------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------------
  assign conv_last = (cyc_ff == adc_seq_pkg::CONV_CNT_W'(adc_seq_pkg::CONV_CYCLES - 1));
  assign decide    = (state_ff == ST_CONV) &&
                     (cyc_ff >= adc_seq_pkg::CONV_CNT_W'(adc_seq_pkg::SETTLE_CYCLES)) &&
                     (phase_ff == adc_seq_pkg::PHASE_W'(adc_seq_pkg::BIT_CYCLES - 1));

  // fixed 36-cycle conversion
  // 36 cycles at 20 ns stay far inside the 17 us ceiling
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (conv_go) begin
            state_ff <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (conv_last) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // cycle and bit-phase counters
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_ff   <= '0;
      phase_ff <= '0;
    end else if (state_ff != ST_CONV) begin
      cyc_ff   <= '0;
      phase_ff <= '0;
    end else begin
      cyc_ff <= cyc_ff + 1'b1;
      if (cyc_ff >= adc_seq_pkg::CONV_CNT_W'(adc_seq_pkg::SETTLE_CYCLES)) begin
        phase_ff <= phase_ff + 1'b1;
      end
    end
  end

  // successive approximation, msb trial first
  assign trial_code = sar_ff | mask_ff;
  assign trial_ok   = (sample_ff >= trial_level(trial_code, ref_lo, ref_hi));

  always_ff @(posedge clk) begin
    if (rst) begin
      sar_ff  <= '0;
      mask_ff <= adc_seq_pkg::SAR_FIRST_MASK;
    end else if (conv_go) begin
      sar_ff  <= '0;
      mask_ff <= adc_seq_pkg::SAR_FIRST_MASK;
    end else if (decide) begin
      if (trial_ok) begin
        sar_ff <= trial_code;
      end
      mask_ff <= mask_ff >> 1;
    end
  end

  always_comb begin
    nxt_result = trial_ok ? trial_code : sar_ff;
    if (sample_ff >= ref_hi) begin
      nxt_result = adc_seq_pkg::RESULT_ONES;
    end else if (sample_ff < ref_lo) begin
      nxt_result = adc_seq_pkg::RESULT_ZERO;
    end
  end

  // result latched at conversion end
  // the last bit decision lands in the same cycle as the load
  always_ff @(posedge clk) begin
    if (rst) begin
      out_ff <= adc_seq_pkg::RESULT_RESET;
    end else if ((state_ff == ST_CONV) && conv_last) begin
      out_ff <= nxt_result;
    end
  end

  // ------------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------------
  assign busy           = (state_ff == ST_CONV);
  assign result         = out_ff;
  assign hold_violation = hold_viol_ff;

endmodule

// *** dv/adc_seq_checker.sv ***
// concurrent checks on the readout sequencer ports
`timescale 1ns/100ps
module adc_seq_checker #(
  parameter int SAMPLE_W   = 10,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                io_clk,
  input wire logic                sel_n,
  input wire logic                sdo,
  input wire logic                sdo_oe,
  input wire logic                ain_valid,
  input wire logic [SAMPLE_W-1:0] ain_data,
  input wire logic                ain_ready,
  input wire logic [SAMPLE_W-1:0] ref_hi,
  input wire logic [SAMPLE_W-1:0] ref_lo,
  input wire logic                busy,
  input wire logic [7:0]          result,
  input wire logic                hold_violation
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------
  // helper logic
  // ----------------
  logic [6:0] busy_len_ff;

  // busy run length, counted rather than unrolled
  always_ff @(posedge clk) begin
    if (rst || !busy) begin
      busy_len_ff <= 7'h00;
    end else begin
      busy_len_ff <= busy_len_ff + 7'h01;
    end
  end

  // short select dip while the output is idle
  sequence s_sel_glitch;
    (!sdo_oe && sel_n) ##1 (!sel_n)[*2] ##1 sel_n;
  endsequence

  // select held low long enough to open
  sequence s_sel_held;
    (!sel_n)[*7];
  endsequence

  // ----------------
  // assertions
  // ----------------
  // conversion length
  a_conv_len: assert property ($fell(busy) |-> busy_len_ff == 7'h24)
    else $error("conversion length wrong");
  a_result_hold: assert property (!$fell(busy) |-> $stable(result))
    else $error("result moved outside completion");
  a_oe_release: assert property (sel_n[*4] |-> !sdo_oe)
    else $error("output still driven with select high");
  a_oe_filter: assert property (s_sel_glitch |-> (!sdo_oe)[*4])
    else $error("short select dip opened an access");
  a_oe_open: assert property (s_sel_held |-> sdo_oe)
    else $error("access did not open");
  a_msb_out: assert property ($rose(sdo_oe) && !busy |-> sdo == result[7])
    else $error("first bit is not the stored msb");
  a_sdo_quiet: assert property (!sdo_oe |-> !sdo)
    else $error("data active while released");
  a_ready_full: assert property ($fell(ain_ready) |-> $past(ain_valid))
    else $error("ready fell without a push");
endmodule

// *** dv/select_host.sv ***
// host model driving select and shift clock, reading serial data
`timescale 1ns/100ps
module select_host #(
  parameter int LEAD_CYC = 70,
  parameter int HOLD_CYC = 850
) (
  input  wire logic clk,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  output logic      io_clk,
  output logic      sel_n
);
  wire logic line_lvl;

  // no pull on the data line, a released line floats
  assign line_lvl = sdo_oe ? sdo : 1'bz;

  // shift clock stands still low outside frames
  initial begin
    io_clk = 1'b0;
    sel_n = 1'b1;
  end

  // lead time before clocking
  // frame only: select low, shift, select high; no hold-off after it
  task automatic frame(input int edges, output logic [7:0] word);
    int k;
    word = 8'h00;
    @(posedge clk);
    sel_n <= 1'b0;
    repeat (LEAD_CYC) @(posedge clk);
    #3;
    for (k = 0; k < edges; k++) begin
      #7.5 io_clk = 1'b1;
      if (k < 8) begin
        word[7-k] = line_lvl;
      end
      #7.5 io_clk = 1'b0;
    end
    @(posedge clk);
    sel_n <= 1'b1;
  endtask

  task automatic access(input int edges, output logic [7:0] word);
    frame(edges, word);
    repeat (HOLD_CYC) @(posedge clk);
  endtask

  // select dip of n cycles, too short to count
  task automatic pulse(input int n);
    @(posedge clk);
    sel_n <= 1'b0;
    repeat (n) @(posedge clk);
    sel_n <= 1'b1;
  endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench for the readout sequencer
`timescale 1ns/100ps
module tb;
  localparam int SW = adc_seq_pkg::SAMPLE_W;
  localparam logic [SW-1:0] LO  = 10'h040;
  localparam logic [SW-1:0] HI  = 10'h240;
  // mid sample, odd step so the code is unambiguous
  localparam logic [SW-1:0] MID = 10'h0D7;
  logic          clk;
  logic          rst;
  logic          io_clk;
  logic          sel_n;
  logic          sdo;
  logic          sdo_oe;
  logic          ain_valid;
  logic [SW-1:0] ain_data;
  logic          ain_ready;
  logic          busy;
  logic [7:0]    result;
  logic          hold_violation;
  logic [7:0]    word;
  int            err_total;
  int            comparisons;

  serial_adc_readout_sequencer #(
    .SAMPLE_W  (SW),
    .FIFO_DEPTH(adc_seq_pkg::FIFO_DEPTH)
  ) dut (
    .clk(clk), .rst(rst), .io_clk(io_clk), .sel_n(sel_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .ain_valid(ain_valid), .ain_data(ain_data), .ain_ready(ain_ready), .ref_hi(HI),
    .ref_lo(LO), .busy(busy), .result(result), .hold_violation(hold_violation)
  );

  select_host host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .io_clk(io_clk), .sel_n(sel_n));

  initial begin
    clk = 1'b0;
  end
  always #10 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // even slots saturate high, odd slots low
  function automatic logic [SW-1:0] smp(input int n);
    return n[0] ? 10'h010 : HI;
  endfunction

  task automatic t_reset();
    @(negedge clk);
    check("sdo_oe", sdo_oe, 1'b0);
    check("result", result, adc_seq_pkg::RESULT_RESET);
    check("ain_ready", ain_ready, 1'b1);
    check("hold flag reset", hold_violation, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_glitch();
    logic seen_oe;
    seen_oe = 1'b0;
    host.pulse(2);
    // watch every cycle, a brief opening must not slip by
    repeat (8) begin
      @(negedge clk);
      seen_oe = seen_oe | sdo_oe;
    end
    check("sdo_oe glitch", seen_oe, 1'b0);
    $display("test glitch done");
  endtask

  // fill until the buffer refuses, nobody draining
  task automatic t_fill();
    int k;
    int n;
    logic rdy;
    n = 0;
    @(posedge clk);
    ain_valid <= 1'b1;
    ain_data <= smp(0);
    for (k = 0; k < 20; k++) begin
      @(negedge clk);
      rdy = ain_ready;
      @(posedge clk);
      if (rdy) begin
        n++;
        ain_data <= smp(n);
      end
    end
    ain_valid <= 1'b0;
    @(negedge clk);
    check("words taken", n, adc_seq_pkg::FIFO_DEPTH);
    check("ready full", ain_ready, 1'b0);
    $display("test fill done");
  endtask

  // each access shows the previous conversion, oldest sample first
  task automatic t_drain();
    int k;
    host.access(8, word);
    check("first word", word, adc_seq_pkg::RESULT_RESET);
    check("ready popped", ain_ready, 1'b1);
    for (k = 0; k < 16; k++) begin
      host.access(8, word);
      check("drained", word, k[0] ? adc_seq_pkg::RESULT_ZERO : adc_seq_pkg::RESULT_ONES);
      check("busy idle", busy, 1'b0);
    end
    $display("test drain done");
  endtask

  // a short access must not convert
  task automatic t_short();
    ain_valid <= 1'b1;
    ain_data <= MID;
    @(posedge clk);
    ain_valid <= 1'b0;
    host.access(5, word);
    check("short word", word, adc_seq_pkg::RESULT_ZERO);
    host.access(8, word);
    check("no start", word, adc_seq_pkg::RESULT_ZERO);
    host.access(8, word);
    check("mid word", word, 8'h4B);
    check("result port", result, 8'h4B);
    $display("test short done");
  endtask

  // select back low while a conversion still runs
  task automatic t_early();
    host.frame(8, word);
    repeat (4) @(posedge clk);
    host.access(8, word);
    check("early word", word, 8'h4B);
    check("hold flag set", hold_violation, 1'b1);
    host.access(8, word);
    check("hold flag clear", hold_violation, 1'b0);
    $display("test early done");
  endtask

  initial begin
    rst = 1'b1;
    ain_valid = 1'b0;
    ain_data = 10'h000;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_glitch();
    t_fill();
    t_drain();
    t_short();
    t_early();
    summarize();
  end

  // watchdog, about twice the expected run
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule

bind serial_adc_readout_sequencer adc_seq_checker #(
  .SAMPLE_W  (SAMPLE_W),
  .FIFO_DEPTH(FIFO_DEPTH)
) chk (
  .clk(clk), .rst(rst), .io_clk(io_clk), .sel_n(sel_n), .sdo(sdo), .sdo_oe(sdo_oe),
  .ain_valid(ain_valid), .ain_data(ain_data), .ain_ready(ain_ready), .ref_hi(ref_hi),
  .ref_lo(ref_lo), .busy(busy), .result(result), .hold_violation(hold_violation)
);
